// file: hw/bssj_pkg.sv
`default_nettype none
package bssj_pkg;

  // Opcode encodings
  localparam logic [7:0] OP_SET_CARRY = 8'h00_D3;
  localparam logic [7:0] OP_SET_BIT = 8'h00_D2;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h00_80;
  localparam logic [7:0] OP_SUB_DIRECT = 8'h00_95;
  localparam logic [7:0] OP_SUB_IMM = 8'h00_94;
  localparam logic [4:0] OP_SUB_BANK_HI = 5'h0_13;  // 10011rrr
  localparam logic [6:0] OP_SUB_IND_HI = 7'h0_4B;   // 1001011i

  // Special function register addresses kept inside the core
  localparam logic [7:0] SFR_ACC_ADDR = 8'h00_E0;
  localparam logic [7:0] SFR_STATUS_ADDR = 8'h00_D0;

  // Status word field positions
  localparam int unsigned ST_CARRY_BIT = 7;
  localparam int unsigned ST_AUX_BIT = 6;
  localparam int unsigned ST_BANK_HI = 4;
  localparam int unsigned ST_BANK_LO = 3;
  localparam int unsigned ST_OVF_BIT = 2;

  // Bit-addressable area: bit addresses below this map to RAM bytes
  localparam logic [7:0] BIT_SFR_START = 8'h00_80;
  localparam logic [3:0] BIT_RAM_BASE_HI = 4'h2;

  // Reset values
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00_00;
  localparam logic [7:0] STATUS_RESET = 8'h00_00;

  // Instruction lengths in bytes
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;

  // Clock phases of one machine cycle, Gray coded along the path
  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_OPERAND = 2'b01,
    PH_DATA = 2'b11,
    PH_FINISH = 2'b10
  } bssj_phase_t;

  // Decoded instruction kind
  typedef enum logic [2:0] {
    K_NONE = 3'd0,
    K_SET_CARRY = 3'd1,
    K_SET_BIT = 3'd2,
    K_SHORT_JUMP = 3'd3,
    K_SUB_BANK = 3'd4,
    K_SUB_IND = 3'd5,
    K_SUB_DIRECT = 3'd6,
    K_SUB_IMM = 3'd7
  } bssj_kind_t;

  // Whole state of the core
  typedef struct packed {
    bssj_phase_t phase;
    bssj_kind_t kind;
    logic second_mc;
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] status;
    logic [7:0] operand;
    logic [2:0] bit_index;
    logic [15:0] code_addr;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    logic done;
    logic unknown;
  } bssj_state_t;

endpackage : bssj_pkg
`default_nettype wire

// file: hw/bssj_sub.sv
`default_nettype none
// Eight-bit subtract with borrow and the three borrow flags
module bssj_sub (
  input wire logic [7:0] i_minuend,
  input wire logic [7:0] i_subtrahend,
  input wire logic i_borrow,
  output logic [7:0] o_diff,
  output logic o_borrow7,
  output logic o_borrow3,
  output logic o_overflow
);

  logic [8:0] full_diff;
  logic [4:0] low_nibble;
  logic [7:0] low_seven;

  // Widened differences; the top bit of each is the borrow out
  always_comb begin
    full_diff = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {8'h00, i_borrow};
    low_nibble = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]} - {4'h0, i_borrow};
    low_seven = {1'b0, i_minuend[6:0]} - {1'b0, i_subtrahend[6:0]} - {7'h00, i_borrow};
    o_diff = full_diff[7:0];
    o_borrow7 = full_diff[8];
    o_borrow3 = low_nibble[4];
    // Signed overflow: borrow into the top bit differs from borrow out of it
    o_overflow = low_seven[7] ^ full_diff[8];
  end

endmodule : bssj_sub
`default_nettype wire

// file: hw/bssj_core.sv
`default_nettype none
// Notes on behaviour
// - Short jump always branches to next plus displacement
// - Displacement is signed, reach minus 128 to 127
// - Short jump opcode 80, two bytes, two cycles
// - Subtract operand and carry from accumulator
// - Carry set on borrow out of bit 7
// - Aux carry set on borrow from bit 3
// - Overflow when borrows out of 6, 7 differ
// - Subtract sources: bank, direct, indirect, immediate
// - Set-bit forces target one, flags otherwise unchanged
module bssj_core (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_code_data,
  input wire logic [7:0] i_ram_rdata,
  output logic [15:0] o_code_addr,
  output logic [7:0] o_ram_addr,
  output logic [7:0] o_ram_wdata,
  output logic o_ram_we,
  output logic [15:0] o_pc,
  output logic [7:0] o_acc,
  output logic [7:0] o_status,
  output logic o_instr_done,
  output logic o_unknown_op
);

  bssj_pkg::bssj_state_t q;
  bssj_pkg::bssj_state_t d;

  logic [7:0] src_byte;
  logic [7:0] sub_diff;
  logic sub_borrow7;
  logic sub_borrow3;
  logic sub_overflow;
  logic [1:0] bank;
  logic [7:0] bit_mask;
  logic [7:0] target_byte;
  logic is_sfr_form;

  assign bank = q.status[bssj_pkg::ST_BANK_HI:bssj_pkg::ST_BANK_LO];

  // Byte at the target address; accumulator and status live in the core, not in RAM
  always_comb begin
    is_sfr_form = (q.kind == bssj_pkg::K_SUB_DIRECT) || (q.kind == bssj_pkg::K_SET_BIT);
    if (is_sfr_form && (q.ram_addr == bssj_pkg::SFR_ACC_ADDR)) begin
      target_byte = q.acc;
    end else if (is_sfr_form && (q.ram_addr == bssj_pkg::SFR_STATUS_ADDR)) begin
      target_byte = q.status;
    end else begin
      target_byte = i_ram_rdata;
    end
    bit_mask = 8'h01 << q.bit_index;
  end

  // Source operand: immediate from the code byte, all others from the target byte
  always_comb begin
    if (q.kind == bssj_pkg::K_SUB_IMM) begin
      src_byte = q.operand;
    end else begin
      src_byte = target_byte;
    end
  end

  // Accumulator minus source minus carry
  bssj_sub u_sub (
    .i_minuend(q.acc),
    .i_subtrahend(src_byte),
    .i_borrow(q.status[bssj_pkg::ST_CARRY_BIT]),
    .o_diff(sub_diff),
    .o_borrow7(sub_borrow7),
    .o_borrow3(sub_borrow3),
    .o_overflow(sub_overflow)
  );

  // One machine cycle is four clock phases; the jump repeats them once
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.ram_we = 1'b0;
    case (q.phase)
      bssj_pkg::PH_FETCH: begin
        d.phase = bssj_pkg::PH_OPERAND;
        if (!q.second_mc) begin
          // Opcode is on the code bus; decode it and point RAM at the register
          d.code_addr = q.pc + bssj_pkg::LEN_ONE;
          d.unknown = 1'b0;
          d.ram_addr = {3'b000, bank, 2'b00, i_code_data[0]};
          if (i_code_data == bssj_pkg::OP_SET_CARRY) begin
            d.kind = bssj_pkg::K_SET_CARRY;
          end else if (i_code_data == bssj_pkg::OP_SET_BIT) begin
            d.kind = bssj_pkg::K_SET_BIT;
          end else if (i_code_data == bssj_pkg::OP_SHORT_JUMP) begin
            d.kind = bssj_pkg::K_SHORT_JUMP;
          end else if (i_code_data[7:3] == bssj_pkg::OP_SUB_BANK_HI) begin
            d.kind = bssj_pkg::K_SUB_BANK;
            d.ram_addr = {3'b000, bank, i_code_data[2:0]};
          end else if (i_code_data[7:1] == bssj_pkg::OP_SUB_IND_HI) begin
            d.kind = bssj_pkg::K_SUB_IND;
            d.ram_addr = {3'b000, bank, 2'b00, i_code_data[0]};
          end else if (i_code_data == bssj_pkg::OP_SUB_DIRECT) begin
            d.kind = bssj_pkg::K_SUB_DIRECT;
          end else if (i_code_data == bssj_pkg::OP_SUB_IMM) begin
            d.kind = bssj_pkg::K_SUB_IMM;
          end else begin
            // Anything else is skipped as a one-byte no-op and flagged
            d.kind = bssj_pkg::K_NONE;
            d.unknown = 1'b1;
          end
        end
      end
      bssj_pkg::PH_OPERAND: begin
        d.phase = bssj_pkg::PH_DATA;
        if (!q.second_mc) begin
          // Second code byte and the register contents are both valid here
          d.operand = i_code_data;
          d.bit_index = i_code_data[2:0];
          case (q.kind)
            bssj_pkg::K_SUB_IND: begin
              d.ram_addr = i_ram_rdata;
            end
            bssj_pkg::K_SUB_DIRECT: begin
              d.ram_addr = i_code_data;
            end
            bssj_pkg::K_SET_BIT: begin
              if (i_code_data < bssj_pkg::BIT_SFR_START) begin
                d.ram_addr = {bssj_pkg::BIT_RAM_BASE_HI, i_code_data[6:3]};
              end else begin
                d.ram_addr = {i_code_data[7:3], 3'b000};
              end
            end
            default: begin
              d.ram_addr = q.ram_addr;
            end
          endcase
        end
      end
      bssj_pkg::PH_DATA: begin
        d.phase = bssj_pkg::PH_FINISH;
        if (!q.second_mc) begin
          d.pc = q.pc + bssj_pkg::LEN_ONE;
          case (q.kind)
            bssj_pkg::K_SET_CARRY: begin
              // Only the carry moves; the other status bits are kept
              d.status[bssj_pkg::ST_CARRY_BIT] = 1'b1;
            end
            bssj_pkg::K_SET_BIT: begin
              d.pc = q.pc + bssj_pkg::LEN_TWO;
              if (q.ram_addr == bssj_pkg::SFR_ACC_ADDR) begin
                d.acc = q.acc | bit_mask;
              end else if (q.ram_addr == bssj_pkg::SFR_STATUS_ADDR) begin
                d.status = q.status | bit_mask;
              end else begin
                // Read-modify-write keeps the seven neighbouring bits
                d.ram_wdata = target_byte | bit_mask;
                d.ram_we = 1'b1;
              end
            end
            bssj_pkg::K_SHORT_JUMP: begin
              // Sign extension gives the reach back 128 and forward 127
              d.pc = q.pc + bssj_pkg::LEN_TWO + {{8{q.operand[7]}}, q.operand};
            end
            bssj_pkg::K_SUB_BANK, bssj_pkg::K_SUB_IND,
            bssj_pkg::K_SUB_DIRECT, bssj_pkg::K_SUB_IMM: begin
              if ((q.kind == bssj_pkg::K_SUB_DIRECT) || (q.kind == bssj_pkg::K_SUB_IMM)) begin
                d.pc = q.pc + bssj_pkg::LEN_TWO;
              end
              d.acc = sub_diff;
              d.status[bssj_pkg::ST_CARRY_BIT] = sub_borrow7;
              d.status[bssj_pkg::ST_AUX_BIT] = sub_borrow3;
              d.status[bssj_pkg::ST_OVF_BIT] = sub_overflow;
            end
            default: begin
              d.pc = q.pc + bssj_pkg::LEN_ONE;
            end
          endcase
        end
      end
      bssj_pkg::PH_FINISH: begin
        d.phase = bssj_pkg::PH_FETCH;
        if ((q.kind == bssj_pkg::K_SHORT_JUMP) && !q.second_mc) begin
          // The jump spends a second, idle machine cycle
          d.second_mc = 1'b1;
        end else begin
          d.second_mc = 1'b0;
          d.done = 1'b1;
          d.code_addr = q.pc;
        end
      end
      default: begin
        d.phase = bssj_pkg::PH_FETCH;
      end
    endcase
  end

  // Single state register; the reset leaves the core fetching at address zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '{
        phase: bssj_pkg::PH_FETCH,
        kind: bssj_pkg::K_NONE,
        second_mc: 1'b0,
        pc: bssj_pkg::PC_RESET,
        acc: bssj_pkg::ACC_RESET,
        status: bssj_pkg::STATUS_RESET,
        operand: 8'h00,
        bit_index: 3'b000,
        code_addr: bssj_pkg::PC_RESET,
        ram_addr: 8'h00,
        ram_wdata: 8'h00,
        ram_we: 1'b0,
        done: 1'b0,
        unknown: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_code_addr = q.code_addr;
  assign o_ram_addr = q.ram_addr;
  assign o_ram_wdata = q.ram_wdata;
  assign o_ram_we = q.ram_we;
  assign o_pc = q.pc;
  assign o_acc = q.acc;
  assign o_status = q.status;
  assign o_instr_done = q.done;
  assign o_unknown_op = q.unknown;

endmodule : bssj_core
`default_nettype wire

// file: sim/bssj_core_chk.sv
`default_nettype none
// Port-level timing and arithmetic checks for the core
module bssj_core_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_code_data,
  input wire logic [7:0] i_ram_rdata,
  input wire logic [15:0] o_code_addr,
  input wire logic [7:0] o_ram_addr,
  input wire logic [7:0] o_ram_wdata,
  input wire logic o_ram_we,
  input wire logic [15:0] o_pc,
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_status,
  input wire logic o_instr_done,
  input wire logic o_unknown_op
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Reference borrow chain packed as {carry, aux, difference, overflow}
  function automatic logic [10:0] sbb(logic [7:0] a, logic [7:0] b, logic c);
    logic [8:0] d;
    logic [4:0] l;
    logic [7:0] m;
    d = {1'b0, a} - {1'b0, b} - 9'(c);
    l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
    m = {1'b0, a[6:0]} - {1'b0, b[6:0]} - 8'(c);
    return {d[8], l[4], d[7:0], d[8] ^ m[7]};
  endfunction : sbb
  // The done pulse coincides with the opcode fetch of the next instruction
  wire logic f_jmp = o_instr_done && i_code_data == 8'h80;
  wire logic f_reg = o_instr_done && (i_code_data[7:3] == 5'h13 || i_code_data[7:1] == 7'h4B);
  wire logic f_two = o_instr_done && (i_code_data[7:1] == 7'h4A || i_code_data == 8'hD2);

  a_jump_two_cycles: assert property (f_jmp |=> !o_instr_done [*7] ##1 o_instr_done)
    else $error("short jump did not take two machine cycles");
  a_jump_target_pc: assert property (f_jmp |-> ##8 o_pc == $past(o_code_addr, 8) + 16'h0002
    + {{8{$past(i_code_data[7], 7)}}, $past(i_code_data, 7)})
    else $error("short jump target wrong");
  a_fetch_at_pc: assert property (o_instr_done |-> o_code_addr == o_pc)
    else $error("fetch address differs from pc");
  a_one_machine_cycle: assert property ((o_instr_done && !f_jmp) |=> !o_instr_done [*3] ##1 o_instr_done)
    else $error("instruction not one machine cycle");
  a_two_byte_len: assert property (f_two |-> ##4 o_pc == $past(o_code_addr, 4) + 16'h0002)
    else $error("two byte form advanced pc wrongly");
  a_sub_imm_flags: assert property ((o_instr_done && i_code_data == 8'h94) |-> ##4
    {o_status[7:6], o_acc, o_status[2]} == sbb($past(o_acc, 4), $past(i_code_data, 3), $past(o_status[7], 4)))
    else $error("immediate subtract result wrong");
  a_sub_reg_flags: assert property (f_reg |-> ##4
    {o_status[7:6], o_acc, o_status[2]} == sbb($past(o_acc, 4), $past(i_ram_rdata, 2), $past(o_status[7], 4)))
    else $error("register subtract result wrong");
  a_set_carry_only: assert property ((o_instr_done && i_code_data == 8'hD3) |-> ##4
    o_status == ($past(o_status, 4) | 8'h80) && o_acc == $past(o_acc, 4))
    else $error("carry set disturbed other state");
  a_set_bit_write: assert property ((o_instr_done && i_code_data == 8'hD2) ##1 !i_code_data[7] |-> ##2
    o_ram_we && o_ram_addr == {4'h2, $past(i_code_data[6:3], 2)}
    && o_ram_wdata == ($past(i_ram_rdata) | (8'h01 << $past(i_code_data[2:0], 2))))
    else $error("bit set write wrong");
endmodule : bssj_core_chk
`default_nettype wire

// file: sim/bssj_mem_model.sv
`default_nettype none
// Program and data memory, both answering in the same cycle
module bssj_mem_model (
  input wire logic i_clock,
  input wire logic [15:0] i_code_addr,
  input wire logic [7:0] i_ram_addr,
  input wire logic [7:0] i_ram_wdata,
  input wire logic i_ram_we,
  output logic [7:0] o_code_data,
  output logic [7:0] o_ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rom [256];
  logic [7:0] ram [256];
  // Beyond the loaded page a changing pattern: the inverted low byte of the address
  assign o_code_data = i_code_addr[15:8] == 8'h00 ? rom[i_code_addr[7:0]] : ~i_code_addr[7:0];
  assign o_ram_rdata = ram[i_ram_addr];
  // Write lands on the edge closing the finish phase
  always @(posedge i_clock) begin
    if (i_ram_we) begin
      ram[i_ram_addr] <= i_ram_wdata;
    end
  end
endmodule : bssj_mem_model
`default_nettype wire

// file: sim/bit_set_short_jump_subtract_exec_bench.sv
`default_nettype none
module bit_set_short_jump_subtract_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst, ram_we, done, unknown;
  logic [7:0] code_data, ram_rdata, ram_addr, ram_wdata, acc, status;
  logic [15:0] code_addr, pc;
  logic [31:0] seed;
  int errors, n_compared, macc, mst, mpc, muk;
  int mram [256];
  // Program: every subtract form, both set forms, jumps at both limits, then a
  // closing loop through three undecoded opcodes that must act as no-ops
  byte unsigned low [25] = '{8'h94, 0, 8'hD3, 8'h95, 8'h30, 8'h9A, 8'h97, 8'hD2, 8'h05,
    8'hD2, 8'hD3, 8'h9A, 8'h95, 8'hE0, 8'h95, 8'hD0, 8'h80, 8'h7F, 0, 0, 0, 8'hD2, 8'hE7,
    8'h80, 8'hF9};

  bssj_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_code_data(code_data),
    .i_ram_rdata(ram_rdata), .o_code_addr(code_addr), .o_ram_addr(ram_addr),
    .o_ram_wdata(ram_wdata), .o_ram_we(ram_we), .o_pc(pc), .o_acc(acc), .o_status(status),
    .o_instr_done(done), .o_unknown_op(unknown));
  bssj_mem_model mem (.i_clock(i_clock), .i_code_addr(code_addr), .i_ram_addr(ram_addr),
    .i_ram_wdata(ram_wdata), .i_ram_we(ram_we), .o_code_data(code_data),
    .o_ram_rdata(ram_rdata));

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Accumulator and status live in the core, not in RAM
  function automatic int rd(int a);
    return a == 224 ? macc : (a == 208 ? mst : mram[a]);
  endfunction : rd
  task automatic step();
    int op, b, s, a, d, l, m, c;
    muk = 0;
    op = mem.rom[mpc];
    b = mem.rom[mpc + 1];
    c = (mst >> 7) & 1;
    if (op == 8'hD3) begin
      mst = mst | 128;
      mpc += 1;
    end else if (op == 8'hD2) begin
      a = b < 128 ? 32 + b / 8 : b & 248;
      d = rd(a) | (1 << (b % 8));
      if (a == 224) macc = d;
      else if (a == 208) mst = d;
      else mram[a] = d;
      mpc += 2;
    end else if (op == 8'h80) begin
      mpc = mpc + 2 + (b > 127 ? b - 256 : b);
    end else if (op < 8'h94 || op > 8'h9F) begin
      // Undecoded: one byte skipped, nothing else moves
      muk = 1;
      mpc += 1;
    end else begin
      if (op == 8'h94) s = b;
      else if (op == 8'h95) s = rd(b);
      else if (op >= 8'h98) s = mram[(mst & 24) + op % 8];
      else s = mram[mram[(mst & 24) + op % 2]];
      d = macc - s - c;
      l = macc % 16 - s % 16 - c;
      m = macc % 128 - s % 128 - c;
      mst = (mst & 8'h3B) | (d < 0 ? 128 : 0) | (l < 0 ? 64 : 0) | ((m < 0) != (d < 0) ? 4 : 0);
      macc = d & 255;
      mpc += op < 8'h96 ? 2 : 1;
    end
  endtask : step
  task automatic cmp(string n, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : cmp
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // Whole run is near 100 cycles; this allows far more
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
  initial begin
    i_rst = 1'b1;
    seed = 32'hc448_2ff5;
    for (int i = 0; i < 256; i++) begin
      seed = xs(seed);
      mem.ram[i] = seed[7:0];
      mram[i] = seed[7:0];
      mem.rom[i] = i < 25 ? low[i] : 8'h00;
    end
    seed = xs(seed);
    mem.rom[1] = seed[7:0];
    mem.rom[146] = seed[15:8];
    mem.rom[145] = 8'h94;
    mem.rom[147] = 8'h80;
    mem.rom[148] = 8'h80;
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    // Each done pulse closes one instruction; compare against the model
    for (int k = 0; k < 20; k++) begin
      for (int n = 0; n < 12; n++) begin
        @(posedge i_clock);
        #1;
        if (done === 1'b1) break;
      end
      step();
      cmp("done", 16'(done), 16'h0001);
      cmp("acc", 16'(acc), 16'(macc));
      cmp("status", 16'(status), 16'(mst));
      cmp("pc", pc, 16'(mpc));
      cmp("unknown", 16'(unknown), 16'(muk));
    end
    cmp("ram20", 16'(mem.ram[32]), 16'(mram[32]));
    report_and_stop();
  end
endmodule : bit_set_short_jump_subtract_exec_bench

bind bssj_core bssj_core_chk chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_code_data(i_code_data), .i_ram_rdata(i_ram_rdata), .o_code_addr(o_code_addr),
  .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata), .o_ram_we(o_ram_we), .o_pc(o_pc),
  .o_acc(o_acc), .o_status(o_status), .o_instr_done(o_instr_done),
  .o_unknown_op(o_unknown_op));
`default_nettype wire
